// *** logic/prog_req_handler.sv ***
`timescale 1ns/1ns
`default_nettype none
module prog_req_handler
  import prog_req_pkg::*;
(
  input  wire logic        clk_sys_in,
  input  wire logic        rst_n_in,
  input  wire logic [7:0]  rx_data_in,
  input  wire logic        rx_valid_in,
  input  wire logic        rx_last_in,
  output logic             rx_ready_out,
  output logic [7:0]       tx_data_out,
  output logic             tx_last_out,
  output logic             tx_valid_out,
  input  wire logic        tx_ready_in,
  output logic             mem_req_out,
  output logic             mem_we_out,
  output logic [15:0]      mem_addr_out,
  output logic [7:0]       mem_wdata_out,
  input  wire logic [7:0]  mem_rdata_in,
  input  wire logic        mem_ack_in,
  input  wire logic        mem_fail_in,
  output logic             erase_req_out,
  input  wire logic        erase_done_in,
  input  wire logic        erase_fail_in,
  input  wire logic [15:0] erase_fail_addr_in,
  input  wire logic        boot_mode_in,
  input  wire logic        flash_fitted_in
);
  state_e      state_q;
  logic [1:0]  pin_s1_q;
  logic [1:0]  pin_s2_q;
  logic [1:0]  pin_s3_q;
  logic [1:0]  pin_q;
  logic        boot;
  logic        flash;
  logic [7:0]  op_q;
  logic [31:0] hdr_q;
  logic [2:0]  hdr_cnt_q;
  logic [15:0] addr_q;
  logic [15:0] left_q;
  logic [15:0] wstart_q;
  logic [15:0] sum_q;
  logic [7:0]  wbyte_q;
  logic        wlast_q;
  logic        wany_q;
  logic        wfail_q;
  logic        pend_q;
  logic        pend_bad_q;
  logic [15:0] pend_addr_q;
  logic [31:0] rep_q;
  logic [2:0]  rep_left_q;
  logic        mem_req_q;
  logic        mem_we_q;
  logic        erase_req_q;
  logic        rx_ready_q;
  logic        take;
  logic        mem_done;
  logic        wr_ok;
  logic        push_done;
  logic        emit_last;
  logic [7:0]  status;
  state_e      exec_next;
  logic [31:0] exec_rep;
  logic [2:0]  exec_len;
  logic [15:0] exec_addr;
  logic [15:0] exec_left;
  logic [8:0]  fifo_out;

  stream_if #(.WIDTH(FIFO_WIDTH)) tx_if ();

  function automatic logic [2:0] hdr_len(input logic [7:0] op);
    case (op)
      OP_READ:  hdr_len = HDR_READ;
      OP_SUM:   hdr_len = HDR_SUM;
      OP_WRITE: hdr_len = HDR_WRITE;
      default:  hdr_len = 3'h0;
    endcase
  endfunction : hdr_len

  function automatic logic in_range(input logic [15:0] a, input logic [15:0] n);
    logic [16:0] end_a;
    end_a = {1'b0, a} + {1'b0, n} - 17'h1;
    in_range = (n == 16'h0) ? (a <= MEM_TOP) : (end_a <= {1'b0, MEM_TOP});
  endfunction : in_range

  function automatic logic [31:0] wr_reply(input logic bad, input logic [15:0] a);
    wr_reply = {(bad ? RP_BAD : RP_GOOD), a, 8'h00};
  endfunction : wr_reply

  assign boot          = pin_q[0];
  assign flash         = pin_q[1];
  assign take          = rx_valid_in && rx_ready_q;
  assign mem_done      = mem_req_q && mem_ack_in;
  assign wr_ok         = in_range(addr_q, 16'h1);
  assign push_done     = tx_if.valid && tx_if.ready;
  assign emit_last     = (rep_left_q == 3'h1) && (left_q == 16'h0);
  assign rx_ready_out  = rx_ready_q;
  assign mem_req_out   = mem_req_q;
  assign mem_we_out    = mem_we_q;
  assign mem_addr_out  = addr_q;
  assign mem_wdata_out = wbyte_q;
  assign erase_req_out = erase_req_q;
  assign tx_data_out   = fifo_out[7:0];
  assign tx_last_out   = fifo_out[8];

  // Pins from outside: a change counts once stages two and three agree
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      pin_s1_q <= PIN_RESET;
      pin_s2_q <= PIN_RESET;
      pin_s3_q <= PIN_RESET;
      pin_q    <= PIN_RESET;
    end else begin
      pin_s1_q <= {flash_fitted_in, boot_mode_in};
      pin_s2_q <= pin_s1_q;
      pin_s3_q <= pin_s2_q;
      pin_q    <= (pin_s2_q & pin_s3_q) | (pin_q & (pin_s2_q | pin_s3_q));
    end
  end

  always_comb begin
    status               = 8'h00;
    status[ST_PEND_BIT]  = pend_q;
    status[ST_BAD_BIT]   = pend_bad_q;
    status[ST_BOOT_BIT]  = boot;
    status[ST_FLASH_BIT] = flash;
  end

  // Decision taken once a whole acknowledged message is in
  always_comb begin
    exec_next = s_emit;
    exec_rep  = {RP_UNKNOWN, op_q, 16'h0000};
    exec_len  = 3'h2;
    exec_addr = addr_q;
    exec_left = 16'h0;
    case (op_q)
      OP_READ: begin
        if (hdr_cnt_q == HDR_READ) begin
          exec_rep  = {RP_READ, 24'h000000};
          exec_len  = 3'h1;
          exec_addr = hdr_q[23:8];
          if (in_range(hdr_q[23:8], {8'h00, hdr_q[7:0]})) begin
            exec_left = {8'h00, hdr_q[7:0]};
          end
        end
      end
      OP_SUM: begin
        if (hdr_cnt_q == HDR_SUM) begin
          exec_rep  = {RP_SUM, 24'h000000};
          exec_len  = 3'h1;
          exec_addr = hdr_q[31:16];
          if (in_range(hdr_q[31:16], hdr_q[15:0])) begin
            exec_left = hdr_q[15:0];
            exec_next = s_sum;
          end
        end
      end
      OP_SIZEQ: begin
        exec_rep = {RP_SIZE, BUF_SIZE, RSVD_BYTE};
        exec_len = 3'h4;
      end
      OP_STATUS: begin
        exec_rep = {RP_STATUS, status, addr_q};
        exec_len = 3'h4;
      end
      OP_ERASE: begin
        if (boot && flash) begin
          exec_next = s_erase;
        end
      end
      OP_WRITE: begin
        if (hdr_cnt_q == HDR_WRITE) begin
          exec_len = 3'h3;
          // Earlier result goes out now, this one waits for the next write
          if (pend_q) begin
            exec_rep = wr_reply(pend_bad_q, pend_addr_q);
          end else begin
            exec_rep = wr_reply(1'b0, ADDR_ALL_ONES);
          end
        end
      end
      default: begin
      end
    endcase
  end

  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state_q <= s_op;
    end else begin
      unique case (state_q)
        s_op: begin
          if (take) begin
            state_q <= rx_last_in ? s_exec : s_hdr;
          end
        end
        s_hdr: begin
          if (take && rx_last_in) begin
            state_q <= s_exec;
          end else if (take && op_q == OP_WRITE && hdr_cnt_q == HDR_WRITE - 3'h1) begin
            state_q <= s_wdata;
          end
        end
        s_wdata: begin
          if (take) begin
            state_q <= s_wmem;
          end
        end
        s_wmem: begin
          if (!wr_ok || mem_done) begin
            state_q <= wlast_q ? s_exec : s_wdata;
          end
        end
        s_exec: begin
          state_q <= exec_next;
        end
        s_sum: begin
          if (left_q == 16'h0) begin
            state_q <= s_emit;
          end
        end
        s_rmem: begin
          if (push_done && left_q == 16'h1) begin
            state_q <= s_op;
          end
        end
        s_erase: begin
          if (erase_done_in) begin
            state_q <= s_emit;
          end
        end
        s_emit: begin
          if (push_done && rep_left_q == 3'h1) begin
            state_q <= (left_q != 16'h0) ? s_rmem : s_op;
          end
        end
      endcase
    end
  end

  // Registered ready costs a bubble per byte but keeps the pin flop-driven
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rx_ready_q <= 1'b0;
    end else begin
      rx_ready_q <= !take && (state_q == s_op || state_q == s_hdr || state_q == s_wdata);
    end
  end

  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      op_q      <= 8'h00;
      hdr_q     <= 32'h00000000;
      hdr_cnt_q <= 3'h0;
      wbyte_q   <= 8'h00;
      wlast_q   <= 1'b0;
      wany_q    <= 1'b0;
      wfail_q   <= 1'b0;
    end else begin
      if (state_q == s_op && take) begin
        op_q      <= rx_data_in;
        hdr_cnt_q <= 3'h0;
        wany_q    <= 1'b0;
        wfail_q   <= 1'b0;
      end
      if (state_q == s_hdr && take && hdr_cnt_q < hdr_len(op_q)) begin
        hdr_q     <= {hdr_q[23:0], rx_data_in};
        hdr_cnt_q <= hdr_cnt_q + 3'h1;
      end
      if (state_q == s_wdata && take) begin
        wbyte_q <= rx_data_in;
        wlast_q <= rx_last_in;
        wany_q  <= 1'b1;
      end
      if (state_q == s_wmem && (!wr_ok || (mem_done && mem_fail_in))) begin
        wfail_q <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      addr_q   <= 16'h0000;
      wstart_q <= 16'h0000;
      left_q   <= 16'h0000;
      sum_q    <= 16'h0000;
    end else begin
      if (state_q == s_hdr && take && op_q == OP_WRITE && hdr_cnt_q == HDR_WRITE - 3'h1) begin
        addr_q   <= {hdr_q[7:0], rx_data_in};
        wstart_q <= {hdr_q[7:0], rx_data_in};
      end else if (state_q == s_wmem && (!wr_ok || mem_done)) begin
        addr_q <= addr_q + 16'h1;
      end else if (state_q == s_exec) begin
        addr_q <= exec_addr;
        left_q <= exec_left;
        sum_q  <= 16'h0000;
      end else if (state_q == s_sum && mem_done) begin
        // Plain 16-bit add, the carry out is simply lost
        sum_q  <= sum_q + {8'h00, mem_rdata_in};
        left_q <= left_q - 16'h1;
        addr_q <= addr_q + 16'h1;
      end else if (state_q == s_rmem && push_done) begin
        left_q <= left_q - 16'h1;
        addr_q <= addr_q + 16'h1;
      end
    end
  end

  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      pend_q      <= 1'b0;
      pend_bad_q  <= 1'b0;
      pend_addr_q <= 16'h0000;
    end else if (state_q == s_exec && op_q == OP_WRITE && hdr_cnt_q == HDR_WRITE) begin
      pend_q      <= wany_q;
      pend_bad_q  <= wfail_q;
      pend_addr_q <= wstart_q;
    end
  end

  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rep_q      <= 32'h00000000;
      rep_left_q <= 3'h0;
    end else if (state_q == s_exec) begin
      rep_q      <= exec_rep;
      rep_left_q <= exec_len;
    end else if (state_q == s_sum && left_q == 16'h0) begin
      rep_q      <= {RP_SUM, sum_q, 8'h00};
      rep_left_q <= 3'h3;
    end else if (state_q == s_erase && erase_done_in) begin
      rep_q      <= erase_fail_in ? wr_reply(1'b1, erase_fail_addr_in) : wr_reply(1'b0, ADDR_ALL_ONES);
      rep_left_q <= 3'h3;
    end else if (state_q == s_emit && push_done) begin
      rep_q      <= {rep_q[23:0], 8'h00};
      rep_left_q <= rep_left_q - 3'h1;
    end
  end

  // Memory side: a request is held until the memory acknowledges it
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      mem_req_q <= 1'b0;
      mem_we_q  <= 1'b0;
    end else if (mem_done) begin
      mem_req_q <= 1'b0;
      mem_we_q  <= 1'b0;
    end else if (!mem_req_q) begin
      if (state_q == s_wmem && wr_ok) begin
        mem_req_q <= 1'b1;
        mem_we_q  <= 1'b1;
      end else if (state_q == s_sum && left_q != 16'h0) begin
        mem_req_q <= 1'b1;
      end else if (state_q == s_rmem && left_q != 16'h0 && tx_if.ready) begin
        // Space checked at issue; in s_rmem only the read data fills the FIFO
        mem_req_q <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      erase_req_q <= 1'b0;
    end else if (state_q == s_exec && exec_next == s_erase) begin
      erase_req_q <= 1'b1;
    end else if (erase_done_in) begin
      erase_req_q <= 1'b0;
    end
  end

  always_comb begin
    tx_if.valid = 1'b0;
    tx_if.data  = 9'h000;
    if (state_q == s_emit) begin
      tx_if.valid = 1'b1;
      tx_if.data  = {emit_last, rep_q[31:24]};
    end else if (state_q == s_rmem && mem_done) begin
      tx_if.valid = 1'b1;
      tx_if.data  = {(left_q == 16'h1), mem_rdata_in};
    end
  end

  stream_fifo #(
    .WIDTH (FIFO_WIDTH),
    .DEPTH (FIFO_DEPTH)
  ) u_tx_fifo (
    .clk_sys_in    (clk_sys_in),
    .rst_n_in      (rst_n_in),
    .in_port       (tx_if),
    .out_data_out  (fifo_out),
    .out_valid_out (tx_valid_out),
    .out_ready_in  (tx_ready_in)
  );
endmodule : prog_req_handler
`default_nettype wire

// *** logic/prog_req_pkg.sv ***
package prog_req_pkg;
  localparam logic [7:0]  OP_READ        = 8'h11;
  localparam logic [7:0]  OP_SUM         = 8'h12;
  localparam logic [7:0]  OP_SIZEQ       = 8'h13;
  localparam logic [7:0]  OP_STATUS      = 8'h14;
  localparam logic [7:0]  OP_ERASE       = 8'h15;
  localparam logic [7:0]  OP_WRITE       = 8'h17;
  localparam logic [7:0]  RP_READ        = 8'h80;
  localparam logic [7:0]  RP_SUM         = 8'h81;
  localparam logic [7:0]  RP_SIZE        = 8'h82;
  localparam logic [7:0]  RP_STATUS      = 8'h83;
  localparam logic [7:0]  RP_GOOD        = 8'h84;
  localparam logic [7:0]  RP_BAD         = 8'h85;
  localparam logic [7:0]  RP_UNKNOWN     = 8'h86;
  localparam logic [15:0] BUF_SIZE       = 16'h0104;
  localparam logic [7:0]  RSVD_BYTE      = 8'h00;
  localparam logic [15:0] ADDR_ALL_ONES  = 16'hffff;
  localparam logic [15:0] MEM_TOP        = 16'hbfff;
  localparam logic [2:0]  HDR_READ       = 3'h3;
  localparam logic [2:0]  HDR_SUM        = 3'h4;
  localparam logic [2:0]  HDR_WRITE      = 3'h2;
  localparam int          ST_PEND_BIT    = 0;
  localparam int          ST_BAD_BIT     = 1;
  localparam int          ST_BOOT_BIT    = 2;
  localparam int          ST_FLASH_BIT   = 3;
  localparam logic [1:0]  PIN_RESET      = 2'h0;
  localparam int          FIFO_WIDTH     = 9;
  localparam int          FIFO_DEPTH     = 16;
  typedef enum logic [3:0] {
    s_op, s_hdr, s_wdata, s_wmem, s_exec, s_sum, s_rmem, s_erase, s_emit
  } state_e;
endpackage : prog_req_pkg

// *** logic/stream_fifo.sv ***
`timescale 1ns/1ns
`default_nettype none
module stream_fifo
  import prog_req_pkg::*;
#(
  parameter int WIDTH = FIFO_WIDTH,
  parameter int DEPTH = FIFO_DEPTH
) (
  input  wire logic             clk_sys_in,
  input  wire logic             rst_n_in,
  stream_if.snk                 in_port,
  output logic [WIDTH-1:0]      out_data_out,
  output logic                  out_valid_out,
  input  wire logic             out_ready_in
);
  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] FULL = (AW+1)'(DEPTH);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0]    wr_q;
  logic [AW-1:0]    rd_q;
  logic [AW:0]      cnt_q;
  logic             wr_en;
  logic             rd_en;

  assign in_port.ready = (cnt_q != FULL);
  assign wr_en         = in_port.valid && in_port.ready;
  // Output is registered so the consumer sees flop-driven data
  assign rd_en         = (cnt_q != '0) && (!out_valid_out || out_ready_in);

  always_ff @(posedge clk_sys_in) begin
    if (wr_en) begin
      mem_q[wr_q] <= in_port.data;
    end
  end

  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      wr_q  <= '0;
      rd_q  <= '0;
      cnt_q <= '0;
    end else begin
      if (wr_en) begin
        wr_q <= wr_q + AW'(1);
      end
      if (rd_en) begin
        rd_q <= rd_q + AW'(1);
      end
      if (wr_en && !rd_en) begin
        cnt_q <= cnt_q + (AW+1)'(1);
      end else if (!wr_en && rd_en) begin
        cnt_q <= cnt_q - (AW+1)'(1);
      end
    end
  end

  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      out_data_out  <= '0;
      out_valid_out <= 1'b0;
    end else if (rd_en) begin
      out_data_out  <= mem_q[rd_q];
      out_valid_out <= 1'b1;
    end else if (out_ready_in) begin
      out_valid_out <= 1'b0;
    end
  end
endmodule : stream_fifo
`default_nettype wire

// *** logic/stream_if.sv ***
`timescale 1ns/1ns
`default_nettype none
interface stream_if #(parameter int WIDTH = 8) ();
  logic             valid;
  logic             ready;
  logic [WIDTH-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface : stream_if
`default_nettype wire

// *** tb/mem_partner.sv ***
`timescale 1ns/1ns
`default_nettype none
module mem_partner (
  input  wire logic        clk_sys_in,
  input  wire logic        mem_req_in,
  input  wire logic        mem_we_in,
  input  wire logic [15:0] mem_addr_in,
  input  wire logic [7:0]  mem_wdata_in,
  output logic [7:0]       mem_rdata_out,
  output logic             mem_ack_out,
  output logic             mem_fail_out,
  input  wire logic        erase_req_in,
  output logic             erase_done_out,
  output logic             erase_fail_out,
  output logic [15:0]      erase_fail_addr_out,
  input  wire logic [3:0]  delay_in,
  input  wire logic        fail_in,
  input  wire logic [15:0] fail_addr_in
);
  logic [7:0] arr [0:65535];
  logic [3:0] wait_q = 4'h0;
  logic [7:0] ewait_q = 8'h00;
  initial begin
    mem_rdata_out = 8'h00;
    mem_ack_out = 1'b0;
    mem_fail_out = 1'b0;
    erase_done_out = 1'b0;
    erase_fail_out = 1'b0;
    erase_fail_addr_out = 16'h0000;
  end
  // Idle data lines toggle so a stale value is never mistaken for an answer
  always @(posedge clk_sys_in) begin
    mem_ack_out <= 1'b0;
    mem_fail_out <= 1'b0;
    mem_rdata_out <= ~mem_rdata_out;
    if (mem_req_in && !mem_ack_out) begin
      if (wait_q < delay_in) begin
        wait_q <= wait_q + 4'h1;
      end else begin
        wait_q <= 4'h0;
        mem_ack_out <= 1'b1;
        mem_fail_out <= fail_in;
        if (mem_we_in) arr[mem_addr_in] = mem_wdata_in;
        else mem_rdata_out <= arr[mem_addr_in];
      end
    end
  end
  // Short erase time; real parts take seconds
  always @(posedge clk_sys_in) begin
    erase_done_out <= 1'b0;
    erase_fail_out <= 1'b0;
    erase_fail_addr_out <= ~erase_fail_addr_out;
    if (erase_req_in && !erase_done_out) begin
      if (ewait_q < 8'd40) begin
        ewait_q <= ewait_q + 8'h01;
      end else begin
        ewait_q <= 8'h00;
        erase_done_out <= 1'b1;
        erase_fail_out <= fail_in;
        erase_fail_addr_out <= fail_addr_in;
      end
    end
  end
endmodule : mem_partner
`default_nettype wire

// *** tb/prog_req_props.sv ***
`timescale 1ns/1ns
`default_nettype none
module prog_req_props
  import prog_req_pkg::*;
(
  input  wire logic        clk_sys_in,
  input  wire logic        rst_n_in,
  input  wire logic        rx_valid_in,
  input  wire logic        rx_ready_out,
  input  wire logic [7:0]  tx_data_out,
  input  wire logic        tx_last_out,
  input  wire logic        tx_valid_out,
  input  wire logic        tx_ready_in,
  input  wire logic        mem_req_out,
  input  wire logic        mem_we_out,
  input  wire logic [15:0] mem_addr_out,
  input  wire logic        mem_ack_in,
  input  wire logic        erase_req_out,
  input  wire logic        erase_done_in,
  input  wire logic        boot_mode_in,
  input  wire logic        flash_fitted_in
);
  default clocking cb @(posedge clk_sys_in);
  endclocking
  default disable iff (!rst_n_in);

  property tx_held_p;
    tx_valid_out && !tx_ready_in |=> tx_valid_out && $stable(tx_data_out) && $stable(tx_last_out);
  endproperty

  AST_MEM_HOLD:
    assert property (mem_req_out && !mem_ack_in |=> mem_req_out && $stable(mem_addr_out) && $stable(mem_we_out))
      else $error("memory request changed before acknowledge");
  AST_MEM_DROP:
    assert property (mem_req_out && mem_ack_in |=> !mem_req_out)
      else $error("memory request not released after acknowledge");
  AST_MEM_RANGE:
    assert property (mem_req_out |-> mem_addr_out <= MEM_TOP)
      else $error("memory access above top of range");
  AST_RX_GAP:
    assert property (rx_valid_in && rx_ready_out |=> !rx_ready_out)
      else $error("request ready not dropped after a take");
  AST_TX_HOLD:
    assert property (tx_held_p)
      else $error("reply byte changed while stalled");
  AST_ERASE_GATE:
    assert property ($rose(erase_req_out) |-> $past(boot_mode_in, 3) && $past(flash_fitted_in, 3))
      else $error("erase started outside bootstrap with flash");
  AST_ERASE_HOLD:
    assert property (erase_req_out && !erase_done_in |=> erase_req_out)
      else $error("erase request dropped before done");
  AST_ERASE_END:
    assert property (erase_req_out && erase_done_in |=> !erase_req_out)
      else $error("erase request held after done");

  cover property (erase_req_out && erase_done_in);
  cover property (mem_req_out && mem_we_out && mem_ack_in);
  cover property (tx_valid_out && !tx_ready_in);
endmodule : prog_req_props
`default_nettype wire

// *** tb/tb_top.sv ***
`timescale 1ns/1ns
`default_nettype none
module tb_top
  import prog_req_pkg::*;
;
  typedef logic [7:0] bytes_t[$];
  logic        clk, rst_n, rx_valid, rx_last, rx_ready, tx_ready, tx_valid, tx_last, boot, flash, fail;
  logic        mem_req, mem_we, mem_ack, mem_fail, erase_req, erase_done, erase_fail;
  logic [7:0]  rx_data, tx_data, mem_wdata, mem_rdata, st;
  logic [15:0] mem_addr, erase_fail_addr, fail_addr, s;
  logic [3:0]  delay;
  logic [31:0] lfsr_q;
  logic [9:0]  e;
  logic [9:0]  exp_q[$];
  logic [7:0]  shadow[logic [15:0]];
  bytes_t      rsp;
  int          n_mismatch = 0;
  int          checked = 0;

  prog_req_handler DUT (.clk_sys_in(clk), .rst_n_in(rst_n), .rx_data_in(rx_data), .rx_valid_in(rx_valid),
    .rx_last_in(rx_last), .rx_ready_out(rx_ready), .tx_data_out(tx_data), .tx_last_out(tx_last),
    .tx_valid_out(tx_valid), .tx_ready_in(tx_ready), .mem_req_out(mem_req), .mem_we_out(mem_we),
    .mem_addr_out(mem_addr), .mem_wdata_out(mem_wdata), .mem_rdata_in(mem_rdata), .mem_ack_in(mem_ack),
    .mem_fail_in(mem_fail), .erase_req_out(erase_req), .erase_done_in(erase_done), .erase_fail_in(erase_fail),
    .erase_fail_addr_in(erase_fail_addr), .boot_mode_in(boot), .flash_fitted_in(flash));
  mem_partner far_mem (.clk_sys_in(clk), .mem_req_in(mem_req), .mem_we_in(mem_we), .mem_addr_in(mem_addr),
    .mem_wdata_in(mem_wdata), .mem_rdata_out(mem_rdata), .mem_ack_out(mem_ack), .mem_fail_out(mem_fail),
    .erase_req_in(erase_req), .erase_done_out(erase_done), .erase_fail_out(erase_fail),
    .erase_fail_addr_out(erase_fail_addr), .delay_in(delay), .fail_in(fail), .fail_addr_in(fail_addr));

  function automatic logic [7:0] rnd();
    lfsr_q = {lfsr_q[30:0], lfsr_q[31] ^ lfsr_q[21] ^ lfsr_q[1] ^ lfsr_q[0]};
    return lfsr_q[7:0];
  endfunction : rnd

  function automatic bytes_t wrep(input logic [7:0] op, input logic [15:0] a);
    return {op, a[15:8], a[7:0]};
  endfunction : wrep

  function automatic logic [15:0] sum16(input logic [15:0] a, input int n);
    logic [15:0] acc;
    acc = 16'h0000;
    for (int i = 0; i < n; i++) acc = acc + 16'(far_mem.arr[a + 16'(i)]);
    return acc;
  endfunction : sum16

  task automatic end_sim();
    $display("checks %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : end_sim

  task automatic timeout(input string what);
    n_mismatch++;
    $display("[ERR] %s expected done seen timeout", what);
    end_sim();
  endtask : timeout

  task automatic chk8(input string what, input logic [7:0] exp, input logic [7:0] got);
    checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk8

  task automatic chk1(input string what, input logic exp, input logic got);
    checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] %s expected %b seen %b", what, exp, got);
    end
  endtask : chk1

  // Holds each byte until taken; the ready seen here is what the design sampled
  task automatic send(input bytes_t m);
    int n;
    for (int i = 0; i < m.size(); i++) begin
      rx_valid <= 1'b1;
      rx_data <= m[i];
      rx_last <= (i == m.size() - 1);
      n = 0;
      do begin
        @(posedge clk);
        n++;
      end while (rx_ready !== 1'b1 && n < 200);
      if (n >= 200) timeout("request_take");
    end
    rx_valid <= 1'b0;
  endtask : send

  task automatic xact(input bytes_t req, input bytes_t rsp, input int dc_from = 999);
    int n;
    for (int i = 0; i < rsp.size(); i++) exp_q.push_back({i >= dc_from, i == rsp.size() - 1, rsp[i]});
    send(req);
    n = 0;
    // Host holds its next message until the reply is
    while (exp_q.size() != 0 && n < 3000) begin
      @(posedge clk);
      n++;
    end
    if (exp_q.size() != 0) timeout("reply");
    repeat (4) @(posedge clk);
  endtask : xact

  task automatic wr(input logic [15:0] a, input int n, input bytes_t rsp);
    bytes_t m;
    logic [7:0] d;
    m = {OP_WRITE, a[15:8], a[7:0]};
    for (int i = 0; i < n; i++) begin
      d = rnd();
      m.push_back(d);
      if (!fail && a <= MEM_TOP) shadow[a + 16'(i)] = d;
    end
    xact(m, rsp);
  endtask : wr

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  always @(posedge clk) begin
    tx_ready <= (rnd() > 8'h4c);
    if (tx_valid === 1'b1 && tx_ready === 1'b1) begin
      if (exp_q.size() == 0) begin
        n_mismatch++;
        $display("[ERR] reply_byte expected none seen %h", tx_data);
      end else begin
        e = exp_q.pop_front();
        if (e[9] === 1'b0) chk8("reply_byte", e[7:0], tx_data);
        chk1("reply_last", e[8], tx_last);
      end
    end
  end

  initial begin
    lfsr_q = 32'hfe3b8b30;
    rst_n = 1'b0;
    rx_valid = 1'b0;
    rx_last = 1'b0;
    rx_data = 8'h00;
    boot = 1'b0;
    flash = 1'b0;
    fail = 1'b0;
    fail_addr = 16'h1234;
    delay = 4'h0;
    // Bytes forced above 7f so the long sum must wrap past 16 bits
    for (int i = 0; i < 512; i++) far_mem.arr[16'h0400 + 16'(i)] = rnd() | 8'h80;
    far_mem.arr[MEM_TOP] = 8'h5a;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge clk);
    xact({OP_SIZEQ}, {RP_SIZE, BUF_SIZE[15:8], BUF_SIZE[7:0], RSVD_BYTE});
    xact({OP_STATUS}, {RP_STATUS, 8'h00, 8'h00, 8'h00}, 2);
    xact({8'h20}, {RP_UNKNOWN, 8'h20});
    xact({OP_READ, 8'h10}, {RP_UNKNOWN, OP_READ});
    xact({OP_ERASE}, {RP_UNKNOWN, OP_ERASE});
    $display("test basic done");
    wr(16'h1000, 4, wrep(RP_GOOD, ADDR_ALL_ONES));
    delay = 4'h6;
    wr(16'h2000, 3, wrep(RP_GOOD, 16'h1000));
    delay = 4'h0;
    wr(16'h2003, 0, wrep(RP_GOOD, 16'h2000));
    fail = 1'b1;
    wr(16'h3000, 2, wrep(RP_GOOD, ADDR_ALL_ONES));
    fail = 1'b0;
    wr(16'hc000, 1, wrep(RP_BAD, 16'h3000));
    wr(16'h3002, 0, wrep(RP_BAD, 16'hc000));
    wr(16'h3000, 2, wrep(RP_GOOD, ADDR_ALL_ONES));
    wr(16'h3002, 0, wrep(RP_GOOD, 16'h3000));
    foreach (shadow[a]) chk8("mem_cell", shadow[a], far_mem.arr[a]);
    $display("test write done");
    rsp = {RP_READ};
    for (int i = 0; i < 4; i++) rsp.push_back(shadow[16'h1000 + 16'(i)]);
    xact({OP_READ, 8'h10, 8'h00, 8'h04}, rsp);
    xact({OP_READ, 8'h10, 8'h00, 8'h00}, {RP_READ});
    xact({OP_READ, 8'hc0, 8'h00, 8'h04}, {RP_READ});
    rsp = {RP_READ};
    for (int i = 0; i < 255; i++) rsp.push_back(far_mem.arr[16'h0400 + 16'(i)]);
    xact({OP_READ, 8'h04, 8'h00, 8'hff}, rsp);
    $display("test read done");
    s = sum16(16'h0400, 512);
    xact({OP_SUM, 8'h04, 8'h00, 8'h02, 8'h00}, {RP_SUM, s[15:8], s[7:0]});
    xact({OP_SUM, 8'hbf, 8'hff, 8'h00, 8'h01}, {RP_SUM, 8'h00, 8'h5a});
    xact({OP_SUM, 8'hbf, 8'hff, 8'h00, 8'h02}, {RP_SUM});
    $display("test checksum done");
    boot <= 1'b1;
    repeat (8) @(posedge clk);
    xact({OP_ERASE}, {RP_UNKNOWN, OP_ERASE});
    flash <= 1'b1;
    repeat (8) @(posedge clk);
    st = 8'h00;
    st[ST_BOOT_BIT] = 1'b1;
    st[ST_FLASH_BIT] = 1'b1;
    xact({OP_STATUS}, {RP_STATUS, st, 8'h00, 8'h00}, 2);
    xact({OP_ERASE}, wrep(RP_GOOD, ADDR_ALL_ONES));
    fail = 1'b1;
    xact({OP_ERASE}, wrep(RP_BAD, fail_addr));
    fail = 1'b0;
    boot <= 1'b0;
    repeat (8) @(posedge clk);
    xact({OP_ERASE}, {RP_UNKNOWN, OP_ERASE});
    $display("test erase done");
    end_sim();
  end
endmodule : tb_top

bind prog_req_handler prog_req_props u_props (.clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in),
  .rx_valid_in(rx_valid_in), .rx_ready_out(rx_ready_out), .tx_data_out(tx_data_out), .tx_last_out(tx_last_out),
  .tx_valid_out(tx_valid_out), .tx_ready_in(tx_ready_in), .mem_req_out(mem_req_out), .mem_we_out(mem_we_out),
  .mem_addr_out(mem_addr_out), .mem_ack_in(mem_ack_in), .erase_req_out(erase_req_out),
  .erase_done_in(erase_done_in), .boot_mode_in(boot_mode_in), .flash_fitted_in(flash_fitted_in));
`default_nettype wire
